// >>> scb_consts.vh
`ifndef SCB_CONSTS_VH
`define SCB_CONSTS_VH
// geometry
`define SCB_NPORT 12
`define SCB_NTYPE 3
`define SCB_NBKT 36
`define SCB_NTICK 5
`define SCB_LVL_W 24
`define SCB_LEN_W 14
// traffic type indices
`define SCB_T_BC 0
`define SCB_T_FL 1
`define SCB_T_MC 2
// register byte addresses
`define SCB_A_TICK_CFG 12'h000
`define SCB_A_TICK_SEL 12'h004
`define SCB_A_MC_HANDLE 12'h008
`define SCB_A_DROP_CNT 12'h00c
`define SCB_A_TYPE_BASE 12'h010
`define SCB_A_TYPE_END 12'h03f
`define SCB_A_LVL_BASE 12'h100
`define SCB_A_LVL_END 12'h18f
// per-type register word within its 16-byte group
`define SCB_W_EN 2'h0
`define SCB_W_CAP 2'h1
`define SCB_W_THR 2'h2
`define SCB_W_RATE 2'h3
// tick configuration fields
`define SCB_F_MDIV 15:0
`define SCB_F_SDIV 23:16
// tick select codes
`define SCB_SEL_CORE 2'h0
`define SCB_SEL_OFF 2'h1
`define SCB_SEL_DBG 2'h2
// rate configuration fields
`define SCB_F_PKTSEL 0
`define SCB_F_TICK 3:1
`define SCB_F_TOKENS 19:4
`define SCB_F_GAP 27:20
`define SCB_F_RATEW 27:0
// other register fields and address slices
`define SCB_F_CFG 23:0
`define SCB_F_SEL 1:0
`define SCB_F_MCH 0
`define SCB_F_TYPEIDX 5:4
`define SCB_F_LVLIDX 7:2
// multicast bit of the destination address
`define SCB_F_MCBIT 40
// tick index from which no injection happens
`define SCB_TICK_NONE 3'h5
// reset values
`define SCB_RST_MDIV 16'h0028
`define SCB_RST_SDIV 8'h0a
`define SCB_RST_RATE 32'h0140_04a5
`define SCB_RST_CAP 24'h0005c8
`define SCB_RST_THR 24'h0002e4
`define SCB_RST_EN 12'hfff
`endif

// >>> scb_storm_limiter.v
// Operation
// - tick 0 is the divider source divided by master_divide_factor
// - five ticks; each later tick divides the previous by step_divide_factor
// - divider source is core clock, disabled, or debug write bit 0
// - tick settings may change live; counters recover by the next tick
// - one bucket per egress port per type: broadcast, flooding, multicast
// - tokens added periodically, level saturates at capacity
// - level at or above threshold accepts all inspected traffic
// - below threshold drops that port's instance; other ports judged alone
// - drop counter advances once per egress port dropped
// - broadcast means destination address all ones
// - flooding means switched with unknown destination
// - multicast means switched, known, multicast bit set; handling option
// - each bucket enabled individually; disabled bucket never limits
// - count_packets_select chooses packet or byte mode
// - packet mode consumes one token per instance
// - byte mode consumes length plus gap_byte_adjust
// - tick field selects injection tick
// - tokens field gives tokens per injection
// - reset default: packet mode, about 5 percent of 64-byte rate
`include "scb_consts.vh"
`default_nettype none
module scb_storm_limiter (
	input wire ref_clk_i,
	input wire rst_i,
	input wire [11:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	input wire [31:0] debug_write_data_i,
	input wire pkt_valid_i,
	input wire [47:0] pkt_dmac_i,
	input wire pkt_l2_switched_i,
	input wire pkt_da_known_i,
	input wire [`SCB_LEN_W-1:0] pkt_len_i,
	input wire [`SCB_NPORT-1:0] pkt_port_mask_i,
	output reg drop_valid_o,
	output reg [`SCB_NPORT-1:0] drop_mask_o,
	output reg [`SCB_NTICK-1:0] tick_o
);

	// saturating bucket update: clamp at zero, then at capacity
	function [`SCB_LVL_W-1:0] bkt_next;
		input [`SCB_LVL_W-1:0] lvl;
		input [`SCB_LVL_W-1:0] cons;
		input [`SCB_LVL_W-1:0] inj;
		input [`SCB_LVL_W-1:0] cap;
		reg [`SCB_LVL_W-1:0] base;
		reg [`SCB_LVL_W:0] sum;
		begin
			base = (cons > lvl) ? {`SCB_LVL_W{1'b0}} : lvl - cons;
			sum = {1'b0, base} + {1'b0, inj};
			bkt_next = (sum > {1'b0, cap}) ? cap : sum[`SCB_LVL_W-1:0];
		end
	endfunction

	// number of ports dropped in one decision
	function [3:0] popcnt;
		input [`SCB_NPORT-1:0] m;
		integer k;
		begin
			popcnt = 4'h0;
			for (k = 0; k < `SCB_NPORT; k = k + 1) begin
				popcnt = popcnt + {3'h0, m[k]};
			end
		end
	endfunction

	// divide-by helper: a factor of zero behaves as one
	function [15:0] last_cnt;
		input [15:0] f;
		begin
			last_cnt = (f == 16'h0000) ? 16'h0000 : f - 16'h0001;
		end
	endfunction

	// tokens one accepted instance consumes
	function [`SCB_LVL_W-1:0] bkt_cost;
		input pktsel;
		input [`SCB_LEN_W-1:0] len;
		input [7:0] gap;
		begin
			if (pktsel) begin
				bkt_cost = {{(`SCB_LVL_W-1){1'b0}}, 1'b1};
			end else begin
				bkt_cost = {{(`SCB_LVL_W-`SCB_LEN_W){1'b0}}, len} +
					{16'h0000, gap};
			end
		end
	endfunction

	// type group of a per-type register address
	function [1:0] type_idx;
		input [11:0] a;
		reg [11:0] off;
		begin
			off = a - `SCB_A_TYPE_BASE;
			type_idx = off[`SCB_F_TYPEIDX];
		end
	endfunction

	// bucket index of a level read address
	function [5:0] lvl_idx;
		input [11:0] a;
		reg [11:0] off;
		begin
			off = a - `SCB_A_LVL_BASE;
			lvl_idx = off[`SCB_F_LVLIDX];
		end
	endfunction

	// register map, byte addresses, one 32-bit word each
	// 0x000 tick config: master_divide_factor low half, step above it
	// 0x004 tick source: 0 core clock, 2 debug bit 0 edge, else off
	// 0x008 multicast handling: 1 moves unknown group DAs to multicast
	// 0x00c drop counter; any write clears it to this cycle's count
	// 0x010/0x020/0x030 broadcast, flooding, multicast groups:
	//   +0 per-port enable, +4 capacity, +8 threshold, +c rate
	// rate word: count_packets_select, tick index, tokens, gap_byte_adjust
	// tick index above four never injects, so a bucket can be frozen
	// 0x100 upward: live levels, index = type * ports + port
	// unmapped reads return zero and unmapped writes are ignored
	// config is shared per type to keep the flop count down;
	// only the levels and enable bits exist once per type and port
	// every bucket updates each cycle: consume first, then inject,
	// so a packet never sees tokens injected in its own cycle

	reg [31:0] tick_cfg_q;
	reg [1:0] tick_sel_q;
	reg mc_handle_q;
	reg [31:0] drop_cnt_q;
	reg [`SCB_NPORT-1:0] en_q [0:`SCB_NTYPE-1];
	reg [`SCB_LVL_W-1:0] cap_q [0:`SCB_NTYPE-1];
	reg [`SCB_LVL_W-1:0] thr_q [0:`SCB_NTYPE-1];
	reg [31:0] rate_q [0:`SCB_NTYPE-1];
	reg [`SCB_LVL_W-1:0] lvl_q [0:`SCB_NBKT-1];
	reg [`SCB_LVL_W-1:0] lvl_d [0:`SCB_NBKT-1];
	reg [`SCB_NPORT-1:0] drop_d;
	reg [15:0] mcnt_q;
	reg [7:0] scnt_q [1:`SCB_NTICK-1];
	reg dbg_q;
	reg src_ev;
	reg [`SCB_NTICK-1:0] tick_d;
	reg [`SCB_NTYPE-1:0] type_v;
	reg [`SCB_NTYPE-1:0] inj_v;
	wire [1:0] reg_type;
	wire [5:0] reg_lvl;
	integer i_tk;
	integer i_cnt;
	integer t_inj;
	integer i_lv;
	integer t_rst;

	// address slices: type group shared by the write and read decoders, level index for reads
	assign reg_type = type_idx(reg_addr_i);
	assign reg_lvl = lvl_idx(reg_addr_i);

	// divider source select; debug bit is edge-detected
	always @* begin
		if (tick_sel_q == `SCB_SEL_CORE) begin
			src_ev = 1'b1;
		end else if (tick_sel_q == `SCB_SEL_DBG) begin
			src_ev = debug_write_data_i[0] & ~dbg_q;
		end else begin
			src_ev = 1'b0;
		end
	end

	// tick chain: each stage fires in the same cycle as the stage it
	// divides, so tickN always coincides with tick0; a factor of zero
	// or one passes every event through
	// hazard: a live shrink of a factor lets the next tick come early,
	// the >= compare then realigns at once instead of wrapping
	always @* begin
		tick_d[0] = src_ev &&
			(mcnt_q >= last_cnt(tick_cfg_q[`SCB_F_MDIV]));
		for (i_tk = 1; i_tk < `SCB_NTICK; i_tk = i_tk + 1) begin
			tick_d[i_tk] = tick_d[i_tk-1] && ({8'h00, scnt_q[i_tk]} >=
				last_cnt({8'h00, tick_cfg_q[`SCB_F_SDIV]}));
		end
	end

	// divider counters; >= compare lets a live shrink recover at once
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mcnt_q <= 16'h0000;
			dbg_q <= 1'b0;
			for (i_cnt = 1; i_cnt < `SCB_NTICK; i_cnt = i_cnt + 1) begin
				scnt_q[i_cnt] <= 8'h00;
			end
		end else begin
			dbg_q <= debug_write_data_i[0];
			if (tick_d[0]) begin
				mcnt_q <= 16'h0000;
			end else if (src_ev) begin
				mcnt_q <= mcnt_q + 16'h0001;
			end
			for (i_cnt = 1; i_cnt < `SCB_NTICK; i_cnt = i_cnt + 1) begin
				if (tick_d[i_cnt]) begin
					scnt_q[i_cnt] <= 8'h00;
				end else if (tick_d[i_cnt-1]) begin
					scnt_q[i_cnt] <= scnt_q[i_cnt] + 8'h01;
				end
			end
		end
	end

	// packet classification
	always @* begin
		type_v[`SCB_T_BC] = &pkt_dmac_i;
		type_v[`SCB_T_FL] = pkt_l2_switched_i && !pkt_da_known_i &&
			!type_v[`SCB_T_BC] &&
			!(mc_handle_q && pkt_dmac_i[`SCB_F_MCBIT]);
		// option folds flooded multicast addresses into the multicast class
		type_v[`SCB_T_MC] = pkt_l2_switched_i && !type_v[`SCB_T_BC] &&
			pkt_dmac_i[`SCB_F_MCBIT] &&
			(pkt_da_known_i || mc_handle_q);
	end

	// injection strobe per type from the chosen tick
	always @* begin
		for (t_inj = 0; t_inj < `SCB_NTYPE; t_inj = t_inj + 1) begin
			inj_v[t_inj] =
				(rate_q[t_inj][`SCB_F_TICK] < `SCB_TICK_NONE) &&
				tick_q_sel(tick_o, rate_q[t_inj][`SCB_F_TICK]);
		end
	end

	function tick_q_sel;
		input [`SCB_NTICK-1:0] tv;
		input [2:0] idx;
		begin
			tick_q_sel = tv[idx];
		end
	endfunction

	// per-bucket decision and next level
	// the decision looks at the level before this packet; a dropped
	// instance costs nothing, so a storm cannot drain a bucket forever
	always @* begin : bkt_comb
		reg hit;
		reg drop;
		reg [`SCB_LVL_W-1:0] cost;
		reg [`SCB_LVL_W-1:0] inj;
		integer b, bt, bp;
		hit = 1'b0;
		drop = 1'b0;
		cost = {`SCB_LVL_W{1'b0}};
		inj = {`SCB_LVL_W{1'b0}};
		bt = 0;
		bp = 0;
		drop_d = {`SCB_NPORT{1'b0}};
		for (b = 0; b < `SCB_NBKT; b = b + 1) begin
			bt = b / `SCB_NPORT;
			bp = b % `SCB_NPORT;
			hit = pkt_valid_i && type_v[bt] && pkt_port_mask_i[bp] &&
				en_q[bt][bp];
			drop = hit && (lvl_q[b] < thr_q[bt]);
			cost = bkt_cost(rate_q[bt][`SCB_F_PKTSEL], pkt_len_i,
				rate_q[bt][`SCB_F_GAP]);
			if (!hit || drop) begin
				cost = {`SCB_LVL_W{1'b0}};
			end
			inj = inj_v[bt] ?
				{8'h00, rate_q[bt][`SCB_F_TOKENS]} :
				{`SCB_LVL_W{1'b0}};
			lvl_d[b] = bkt_next(lvl_q[b], cost, inj, cap_q[bt]);
			drop_d[bp] = drop_d[bp] | drop;
		end
	end

	// bucket levels and drop outputs
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (i_lv = 0; i_lv < `SCB_NBKT; i_lv = i_lv + 1) begin
				lvl_q[i_lv] <= `SCB_RST_CAP;
			end
			drop_mask_o <= {`SCB_NPORT{1'b0}};
			drop_valid_o <= 1'b0;
			tick_o <= {`SCB_NTICK{1'b0}};
		end else begin
			for (i_lv = 0; i_lv < `SCB_NBKT; i_lv = i_lv + 1) begin
				lvl_q[i_lv] <= lvl_d[i_lv];
			end
			drop_mask_o <= drop_d;
			drop_valid_o <= pkt_valid_i;
			tick_o <= tick_d;
		end
	end

	// register writes; a clearing write wins but still counts this cycle's drops
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cfg_q <= {8'h00, `SCB_RST_SDIV, `SCB_RST_MDIV};
			tick_sel_q <= `SCB_SEL_CORE;
			mc_handle_q <= 1'b0;
			drop_cnt_q <= 32'h0000_0000;
			for (t_rst = 0; t_rst < `SCB_NTYPE; t_rst = t_rst + 1) begin
				en_q[t_rst] <= `SCB_RST_EN;
				cap_q[t_rst] <= `SCB_RST_CAP;
				thr_q[t_rst] <= `SCB_RST_THR;
				rate_q[t_rst] <= `SCB_RST_RATE;
			end
		end else begin
			if (reg_wr_i && reg_addr_i == `SCB_A_DROP_CNT) begin
				drop_cnt_q <= {28'h0000000, popcnt(drop_mask_o)};
			end else begin
				drop_cnt_q <= drop_cnt_q +
					{28'h0000000, popcnt(drop_mask_o)};
			end
			if (reg_wr_i) begin
				if (reg_addr_i == `SCB_A_TICK_CFG) begin
					tick_cfg_q <= {8'h00, reg_wdata_i[`SCB_F_CFG]};
				end else if (reg_addr_i == `SCB_A_TICK_SEL) begin
					tick_sel_q <= reg_wdata_i[`SCB_F_SEL];
				end else if (reg_addr_i == `SCB_A_MC_HANDLE) begin
					mc_handle_q <= reg_wdata_i[`SCB_F_MCH];
				end else if (reg_addr_i >= `SCB_A_TYPE_BASE &&
					reg_addr_i <= `SCB_A_TYPE_END) begin
					if (reg_addr_i[3:2] == `SCB_W_EN) begin
						en_q[reg_type] <= reg_wdata_i[`SCB_NPORT-1:0];
					end else if (reg_addr_i[3:2] == `SCB_W_CAP) begin
						cap_q[reg_type] <= reg_wdata_i[`SCB_LVL_W-1:0];
					end else if (reg_addr_i[3:2] == `SCB_W_THR) begin
						thr_q[reg_type] <= reg_wdata_i[`SCB_LVL_W-1:0];
					end else begin
						rate_q[reg_type] <= {4'h0,
							reg_wdata_i[`SCB_F_RATEW]};
					end
				end
			end
		end
	end

	// read data, one cycle after the strobe, zero when unmapped
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_addr_i == `SCB_A_TICK_CFG) begin
			reg_rdata_o <= tick_cfg_q;
		end else if (reg_addr_i == `SCB_A_TICK_SEL) begin
			reg_rdata_o <= {30'h00000000, tick_sel_q};
		end else if (reg_addr_i == `SCB_A_MC_HANDLE) begin
			reg_rdata_o <= {31'h00000000, mc_handle_q};
		end else if (reg_addr_i == `SCB_A_DROP_CNT) begin
			reg_rdata_o <= drop_cnt_q;
		end else if (reg_addr_i >= `SCB_A_TYPE_BASE &&
			reg_addr_i <= `SCB_A_TYPE_END) begin
			if (reg_addr_i[3:2] == `SCB_W_EN) begin
				reg_rdata_o <= {20'h00000, en_q[reg_type]};
			end else if (reg_addr_i[3:2] == `SCB_W_CAP) begin
				reg_rdata_o <= {8'h00, cap_q[reg_type]};
			end else if (reg_addr_i[3:2] == `SCB_W_THR) begin
				reg_rdata_o <= {8'h00, thr_q[reg_type]};
			end else begin
				reg_rdata_o <= rate_q[reg_type];
			end
		end else if (reg_addr_i >= `SCB_A_LVL_BASE &&
			reg_addr_i <= `SCB_A_LVL_END) begin
			// live bucket level, index = type * ports + port
			reg_rdata_o <= {8'h00, lvl_q[reg_lvl]};
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// >>> scb_storm_limiter_properties.sv
`default_nettype none
module scb_storm_limiter_chk (
	input wire ref_clk_i,
	input wire rst_i,
	input wire reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire pkt_valid_i,
	input wire [11:0] pkt_port_mask_i,
	input wire drop_valid_o,
	input wire [11:0] drop_mask_o,
	input wire [4:0] tick_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// each packet gets exactly one answer, one cycle later
	drop_answer_a: assert property (pkt_valid_i |=> drop_valid_o)
		else $error("no drop decision after packet");
	drop_quiet_a: assert property (!pkt_valid_i |=>
		!drop_valid_o && drop_mask_o == 12'h000)
		else $error("drop output without packet");
	drop_own_port_a: assert property (pkt_valid_i |=>
		(drop_mask_o & ~$past(pkt_port_mask_i)) == 12'h000)
		else $error("drop on port without instance");
	read_quiet_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data outside read slot");
	// every master tick is at least two cycles apart here
	tick_gap_a: assert property (tick_o[0] |=> !tick_o[0])
		else $error("master tick too long");
	tick1_chain_a: assert property (tick_o[1] |-> tick_o[0])
		else $error("tick1 without tick0");
	tick2_chain_a: assert property (tick_o[2] |-> tick_o[1])
		else $error("tick2 without tick1");
	tick4_chain_a: assert property (tick_o[4] |-> tick_o[3])
		else $error("tick4 without tick3");
	tick1_rate_a: assert property (tick_o[1] |=> !tick_o[1] [*3])
		else $error("tick1 faster than divided rate");
	cover property (drop_valid_o && drop_mask_o != 12'h000);
	cover property (tick_o[4]);
	cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule
bind scb_storm_limiter scb_storm_limiter_chk u_chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .pkt_valid_i(pkt_valid_i),
	.pkt_port_mask_i(pkt_port_mask_i), .drop_valid_o(drop_valid_o),
	.drop_mask_o(drop_mask_o), .tick_o(tick_o));
`default_nettype wire

// >>> scb_pipe_model.sv
`default_nettype none
// packet pipeline side: one classified packet per call
module scb_pipe_model (
	input wire logic clk_i,
	output var logic pkt_valid_o,
	output var logic [47:0] pkt_dmac_o,
	output var logic pkt_sw_o,
	output var logic pkt_known_o,
	output var logic [13:0] pkt_len_o,
	output var logic [11:0] pkt_mask_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		pkt_valid_o = 1'b0;
		pkt_dmac_o = 48'h0;
		pkt_sw_o = 1'b0;
		pkt_known_o = 1'b0;
		pkt_len_o = 14'h0;
		pkt_mask_o = 12'h0;
	end
	// fields invert after the pulse so stale values never look valid
	task automatic send(input logic [47:0] da, input logic sw, kn,
		input logic [13:0] len, input logic [11:0] m);
		@(posedge clk_i);
		pkt_valid_o <= 1'b1;
		pkt_dmac_o <= da;
		pkt_sw_o <= sw;
		pkt_known_o <= kn;
		pkt_len_o <= len;
		pkt_mask_o <= m;
		@(posedge clk_i);
		pkt_valid_o <= 1'b0;
		pkt_dmac_o <= ~da;
		pkt_sw_o <= ~sw;
		pkt_known_o <= ~kn;
		pkt_len_o <= ~len;
		pkt_mask_o <= ~m;
	endtask
endmodule
`default_nettype wire

// >>> scb_storm_limiter_tb_top.sv
`default_nettype none
module scb_storm_limiter_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, pkt_valid_i, sw, kn, drop_v;
	logic [11:0] reg_addr_i, pmask, drop_m;
	logic [31:0] reg_wdata_i, rdata, dbg_d;
	logic [47:0] dmac;
	logic [13:0] plen;
	logic [4:0] tick_o;
	int n_errors = 0;
	int compares = 0;
	scb_storm_limiter u_scb_storm_limiter (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
		.debug_write_data_i(dbg_d), .pkt_valid_i(pkt_valid_i),
		.pkt_dmac_i(dmac), .pkt_l2_switched_i(sw), .pkt_da_known_i(kn),
		.pkt_len_i(plen), .pkt_port_mask_i(pmask), .drop_valid_o(drop_v),
		.drop_mask_o(drop_m), .tick_o(tick_o));
	scb_pipe_model u_scb_pipe_model (.clk_i(ref_clk_i),
		.pkt_valid_o(pkt_valid_i), .pkt_dmac_o(dmac), .pkt_sw_o(sw),
		.pkt_known_o(kn), .pkt_len_o(plen), .pkt_mask_o(pmask));
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// read data is only valid in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic pk(input logic [47:0] da, input logic s, k,
		input logic [13:0] l, input logic [11:0] m, e);
		u_scb_pipe_model.send(da, s, k, l, m);
		#1 chk("drop mask", {20'h0, drop_m}, {20'h0, e});
		chk("drop valid", {31'h0, drop_v}, 32'h1);
	endtask
	// first rise may come early after a change; the next gap is exact
	task automatic tgap(input int b, input int e);
		int n;
		n = 0;
		#1;
		while (tick_o[b] !== 1'b1 && n < 300) begin
			@(posedge ref_clk_i);
			#1 n++;
		end
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1 n++;
		end while (tick_o[b] !== 1'b1 && n < 300);
		chk("tick gap", n, e);
	endtask
	task automatic dbg(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			dbg_d[0] <= 1'b1;
			repeat (2) @(posedge ref_clk_i);
			dbg_d[0] <= 1'b0;
			@(posedge ref_clk_i);
		end
	endtask
	task automatic test_done;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		n_errors++;
		test_done;
	end
	initial begin
		int k;
		{rst_i, reg_wr_i, reg_rd_i, reg_addr_i} = {3'b100, 12'h0};
		reg_wdata_i = 32'h0;
		dbg_d = 32'h0;
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd(12'h000, 32'h000a0028);
		rd(12'h004, 32'h0);
		rd(12'h050, 32'h0);
		for (int t = 0; t < 3; t++) begin
			rd(12'(16 * t + 16), 32'hfff);
			rd(12'(16 * t + 20), 32'h5c8);
			rd(12'(16 * t + 24), 32'h2e4);
			rd(12'(16 * t + 28), 32'h014004a5);
			rd(12'(48 * t + 256), 32'h5c8);
		end
		tgap(0, 40);
		wr(12'h000, 32'h00020004);
		tgap(4, 64);
		tgap(1, 8);
		// source disabled: no ticks, so no injection until the debug source is chosen
		wr(12'h004, 32'h1);
		k = 0;
		repeat (2) @(posedge ref_clk_i);
		repeat (50) begin
			@(posedge ref_clk_i);
			#1 k += tick_o[0];
		end
		chk("ticks off", k, 0);
		// broadcast, packet mode, ports 0 and 1
		wr(12'h018, 32'h5c6);
		wr(12'h01c, 32'h0000000f);
		repeat (3) pk('1, 1, 1, 64, 12'h003, 12'h000);
		pk('1, 1, 1, 64, 12'h003, 12'h003);
		rd(12'h00c, 32'h2);
		rd(12'h100, 32'h5c5);
		wr(12'h010, 32'hffd);
		pk('1, 1, 1, 64, 12'h003, 12'h001);
		rd(12'h104, 32'h5c5);
		rd(12'h108, 32'h5c8);
		// flooding in byte mode on port 4, gap 20
		wr(12'h02c, 32'h0140000e);
		pk(48'h020000000001, 1, 0, 100, 12'h010, 12'h000);
		rd(12'h140, 32'h550);
		pk(48'h020000000001, 1, 0, 14'h3fff, 12'h010, 12'h000);
		rd(12'h140, 32'h0);
		pk(48'h020000000001, 1, 0, 100, 12'h010, 12'h010);
		// only multicast limits: one packet of each class on port 6
		wr(12'h038, 32'h00ffffff);
		pk('1, 1, 1, 64, 12'h040, 12'h000);
		pk(48'h020000000001, 1, 0, 64, 12'h040, 12'h000);
		pk(48'h010000000001, 1, 1, 64, 12'h040, 12'h040);
		pk(48'h010000000001, 0, 1, 64, 12'h040, 12'h000);
		rd(12'h00c, 32'h5);
		// debug bit as tick source, one token per master tick
		wr(12'h000, 32'h000a0001);
		wr(12'h01c, 32'h00000011);
		wr(12'h004, 32'h2);
		dbg(2);
		rd(12'h100, 32'h5c7);
		dbg(3);
		rd(12'h100, 32'h5c8);
		test_done;
	end
endmodule
`default_nettype wire
